// ===== scsd_clock_ctl.v
// Function
// [RL1] Source code 000 internal, 001 external
// [RL2] Divider code n divides by 2^n
// [RL3] New divide applied within 128 source cycles
// [RL4] Bit 7 flags divide setting applied
// [RL5] Software sets divide-by-1 before suspend
// [RL6] Source switch on the fly, one slow period
// [RL7] Bit 3 reads 0, software writes 0
// [RL8] Reset selects internal oscillator, register zero; this block reads 0x80 after reset, applied flag in bit 7 set
// [RL9] Internal post-scaler 1/2/4/8, resets to 8
// [RL10] Trim field: zero fastest, ones slowest
// [RL11] Trim loads factory value at reset
// [RL12] Dither only while enable bit is 1
// [RL13] Triangle repeats every 384 oscillator cycles
// [RL14] Step every 32 cycles, within three steps
// [RL15] Post-scaler codes 00/01/10/11 give 8/4/2/1
// [RL16] Oscillator enable stops or runs, resets 1
// [RL17] Source and divide changes are glitch-free
`timescale 1ns/100ps
`default_nettype none
`include "scsd_defs.vh"

module scsd_clock_ctl #(
	parameter HALF_BASE = 4,
	parameter DITHER_UNIT = 1
) (
	input wire clock,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [6:0] trim_factory,
	input wire ext_osc,
	output wire int_osc_out,
	output wire sysclk_out
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	reg [2:0] src_sel_q;
	reg [2:0] div_code_q;
	reg [6:0] trim_q;
	reg trim_loaded_q;
	reg osc_en_q;
	reg dither_en_q;
	reg [1:0] post_code_q;

	reg [9:0] half_cnt_q;
	reg osc_q;
	reg [4:0] upd_cnt_q;
	reg [3:0] phase_q;
	reg [2:0] level_q;

	reg ext_q;
	reg ext_prev_q;

	wire [9:0] half_len;
	wire osc_tog;
	wire osc_rise;
	wire post_lvl;
	wire post_edge;
	wire ext_edge;
	wire sel_ext;
	wire sw_lvl;
	wire sw_edge;
	wire div_applied;
	wire [7:0] src_div_rd;
	wire [7:0] osc_ctl_rd;
	wire hit_src_div;
	wire hit_trim;
	wire hit_osc_ctl;
	wire upd_wrap;
	wire phase_wrap;
	wire [3:0] phase_next;
	reg [7:0] rd_mux;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Triangle around the center level, one entry per dither step
	function [2:0] tri_level;
		input [3:0] phase;
		begin
			case (phase)
				4'h0: tri_level = 3'h3;
				4'h1: tri_level = 3'h4;
				4'h2: tri_level = 3'h5;
				4'h3: tri_level = 3'h6;
				4'h4: tri_level = 3'h5;
				4'h5: tri_level = 3'h4;
				4'h6: tri_level = 3'h3;
				4'h7: tri_level = 3'h2;
				4'h8: tri_level = 3'h1;
				4'h9: tri_level = 3'h0;
				4'ha: tri_level = 3'h1;
				default: tri_level = 3'h2;
			endcase
		end
	endfunction

	function is_addr;
		input [7:0] addr;
		input [7:0] target;
		begin
			is_addr = (addr == target);
		end
	endfunction

	// ------------------------------------------------------------------
	// Local constants
	// ------------------------------------------------------------------
	// Post-scaler power code that means divide by 8
	localparam [1:0] POST_POW_RST = 2'h3;
	// Last dither step and last cycle of a step
	localparam [3:0] LAST_PHASE = 4'hb;
	localparam [4:0] LAST_UPD = 5'h1f;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// One compare per register, shared by writes and reads
	assign hit_src_div = is_addr(reg_addr, `SCSD_ADDR_SRC_DIV);
	assign hit_trim = is_addr(reg_addr, `SCSD_ADDR_TRIM);
	assign hit_osc_ctl = is_addr(reg_addr, `SCSD_ADDR_OSC_CTL);

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	// [RL8] Internal source after reset
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_sel_q <= `SCSD_SRC_INT;
			div_code_q <= `SCSD_DIV_RST;
		end else if (reg_wr && hit_src_div) begin
			// [RL7] Reserved bit and flag bit not stored
			div_code_q <= reg_wdata[`SCSD_DIV_MSB:`SCSD_DIV_LSB];
			src_sel_q <= reg_wdata[`SCSD_SRC_MSB:`SCSD_SRC_LSB];
		end
	end

	// [RL11] Factory trim captured after release
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			trim_q <= 7'h00;
			trim_loaded_q <= 1'b0;
		end else begin
			trim_loaded_q <= 1'b1;
			// A write in the load cycle wins over the strap
			if (reg_wr && hit_trim) begin
				trim_q <= reg_wdata[`SCSD_TRIM_MSB:`SCSD_TRIM_LSB];
			end else if (!trim_loaded_q) begin
				trim_q <= trim_factory;
			end
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// [RL16] Oscillator enabled on reset
			osc_en_q <= `SCSD_OSC_EN_RST;
			dither_en_q <= `SCSD_DITHER_RST;
			// [RL9] Post-scaler back to divide by 8
			post_code_q <= `SCSD_POST_RST;
		end else if (reg_wr && hit_osc_ctl) begin
			osc_en_q <= reg_wdata[`SCSD_OSC_EN_BIT];
			dither_en_q <= reg_wdata[`SCSD_DITHER_BIT];
			post_code_q <= reg_wdata[`SCSD_POST_MSB:`SCSD_POST_LSB];
		end
	end

	// ------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------
	// [RL4] Applied flag in bit 7
	// [RL7] Reserved bit reads zero
	assign src_div_rd = {div_applied, div_code_q, 1'b0, src_sel_q};
	assign osc_ctl_rd = {osc_en_q, osc_en_q, 2'h0, dither_en_q, 1'b0, post_code_q};

	// Unmapped addresses read zero
	always @* begin
		rd_mux = 8'h00;
		if (hit_src_div) begin
			rd_mux = src_div_rd;
		end else if (hit_trim) begin
			rd_mux = {1'b0, trim_q};
		end else if (hit_osc_ctl) begin
			rd_mux = osc_ctl_rd;
		end
	end

	// Data stand only in the cycle after the strobe
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Internal oscillator model
	// ------------------------------------------------------------------
	// Half period in clock cycles grows with the trim value.
	// Dither level 3 is the center, so the disabled case sits there.
	// A trim change acts on the half period already running
	// [RL10] Larger trim, slower oscillator
	assign half_len = HALF_BASE[9:0] + {3'h0, trim_q}
		+ ({7'h00, level_q} * DITHER_UNIT[9:0]);
	assign osc_tog = osc_en_q && (half_cnt_q >= half_len - 10'h001);
	assign osc_rise = osc_tog && !osc_q;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt_q <= 10'h000;
			osc_q <= 1'b0;
		end else if (!osc_en_q) begin
			// [RL16] Stopped oscillator parks low
			half_cnt_q <= 10'h000;
			osc_q <= 1'b0;
		end else if (osc_tog) begin
			half_cnt_q <= 10'h000;
			osc_q <= ~osc_q;
		end else begin
			half_cnt_q <= half_cnt_q + 10'h001;
		end
	end

	// ------------------------------------------------------------------
	// Spread-spectrum dither
	// ------------------------------------------------------------------
	// Twelve steps of 32 cycles make one 384-cycle triangle
	assign upd_wrap = osc_rise && (upd_cnt_q == LAST_UPD);
	assign phase_wrap = (phase_q == LAST_PHASE);
	assign phase_next = phase_wrap ? 4'h0 : phase_q + 4'h1;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			upd_cnt_q <= 5'h00;
			phase_q <= 4'h0;
			level_q <= `SCSD_DITHER_CENTER;
		end else if (!dither_en_q) begin
			// [RL12] No modulation unless enabled
			upd_cnt_q <= 5'h00;
			phase_q <= 4'h0;
			level_q <= `SCSD_DITHER_CENTER;
		end else if (osc_rise) begin
			// [RL14] Update every 32 oscillator cycles
			if (upd_wrap) begin
				upd_cnt_q <= 5'h00;
				// [RL13] Wrap after 384 cycles
				phase_q <= phase_next;
				level_q <= tri_level(phase_next);
			end else begin
				upd_cnt_q <= upd_cnt_q + 5'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// Internal post-scaler
	// ------------------------------------------------------------------
	// [RL15] Code inverted gives the power of two
	// [RL9] Divide by 1, 2, 4 or 8
	scsd_pow2_div #(
		.CODE_W(2),
		.RESET_CODE(POST_POW_RST)
	) u_post (
		.clock(clock),
		.rst_n(rst_n),
		.src_edge(osc_tog),
		.ratio(~post_code_q),
		.out_q(post_lvl),
		.edge_q(post_edge),
		.applied()
	);

	assign int_osc_out = post_lvl;

	// ------------------------------------------------------------------
	// External oscillator sampling
	// ------------------------------------------------------------------
	// Edge flop lets the switch see both edges of the external source
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_q <= ext_osc;
			ext_prev_q <= ext_q;
		end
	end

	assign ext_edge = ext_q ^ ext_prev_q;

	// ------------------------------------------------------------------
	// Source select and system divider
	// ------------------------------------------------------------------
	// Bad codes keep a running source rather than stop the clock
	// [RL1] Only code 001 picks external; reserved codes stay internal
	assign sel_ext = (src_sel_q == `SCSD_SRC_EXT);

	// Sources are sampled, so every phase is whole clock cycles
	// [RL6] Switch waits at most one period of each source
	// [RL17] Output parked low across the handover
	scsd_clk_switch u_switch (
		.clock(clock),
		.rst_n(rst_n),
		.sel(sel_ext),
		.a_lvl(post_lvl),
		.a_edge(post_edge),
		.b_lvl(ext_q),
		.b_edge(ext_edge),
		.out_q(sw_lvl),
		.edge_q(sw_edge)
	);

	// [RL2] Divide by two to the code
	// [RL3] Ratio taken at a falling edge, within 128 cycles
	// [RL17] No shortened phase on ratio change
	// Flag compares live codes: it drops as soon as a new code lands
	scsd_pow2_div #(
		.CODE_W(3),
		.RESET_CODE(`SCSD_DIV_RST)
	) u_sysdiv (
		.clock(clock),
		.rst_n(rst_n),
		.src_edge(sw_edge),
		.ratio(div_code_q),
		.out_q(sysclk_out),
		.edge_q(),
		.applied(div_applied)
	);

	// [RL5] Suspend is outside this block; software keeps divide by 1 there
endmodule // scsd_clock_ctl

`default_nettype wire

// ===== scsd_defs.vh
`ifndef SCSD_DEFS_VH
`define SCSD_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SCSD_ADDR_SRC_DIV 8'hbd
`define SCSD_ADDR_TRIM 8'hbf
`define SCSD_ADDR_OSC_CTL 8'ha9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCSD_APPLIED_BIT 7
`define SCSD_DIV_MSB 6
`define SCSD_DIV_LSB 4
`define SCSD_SRC_MSB 2
`define SCSD_SRC_LSB 0
`define SCSD_TRIM_MSB 6
`define SCSD_TRIM_LSB 0
`define SCSD_OSC_EN_BIT 7
`define SCSD_OSC_RUN_BIT 6
`define SCSD_DITHER_BIT 3
`define SCSD_POST_MSB 1
`define SCSD_POST_LSB 0

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define SCSD_SRC_INT 3'h0
`define SCSD_SRC_EXT 3'h1
`define SCSD_DIV_RST 3'h0
`define SCSD_POST_RST 2'h0
`define SCSD_OSC_EN_RST 1'h1
`define SCSD_DITHER_RST 1'h0

// ----------------------------------------------------------------------
// Dither timing, in internal oscillator cycles
// ----------------------------------------------------------------------
`define SCSD_DITHER_UPDATE 32
`define SCSD_DITHER_PERIOD 384
`define SCSD_DITHER_STEPS (`SCSD_DITHER_PERIOD / `SCSD_DITHER_UPDATE)
`define SCSD_DITHER_CENTER 3'h3

`endif

// ===== scsd_pow2_div.v
`timescale 1ns/100ps
`default_nettype none

// Power-of-two divider driven by edge pulses of its source.
// The output toggles every 2^ratio source edges.
module scsd_pow2_div #(
	parameter CODE_W = 3,
	parameter [CODE_W-1:0] RESET_CODE = {CODE_W{1'b0}}
) (
	input wire clock,
	input wire rst_n,
	input wire src_edge,
	input wire [CODE_W-1:0] ratio,
	output reg out_q,
	output reg edge_q,
	output wire applied
);
	localparam CNT_W = (1 << CODE_W) - 1;

	reg [CODE_W-1:0] cur_q;
	reg [CNT_W-1:0] cnt_q;
	wire [CNT_W-1:0] mask;
	wire tog;

	assign mask = ~({CNT_W{1'b1}} << cur_q);
	assign tog = src_edge && ((cnt_q & mask) == mask);
	assign applied = (cur_q == ratio);

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cur_q <= RESET_CODE;
			cnt_q <= {CNT_W{1'b0}};
			out_q <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			edge_q <= tog;
			if (tog) begin
				out_q <= ~out_q;
			end
			// New ratio only at a falling output edge, so no phase is cut short
			if (tog && out_q) begin
				cur_q <= ratio;
				cnt_q <= {CNT_W{1'b0}};
			end else if (src_edge) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule // scsd_pow2_div

`default_nettype wire

// ===== scsd_clk_switch.v
`timescale 1ns/100ps
`default_nettype none

// Glitch-free two-source switch working on sampled clock levels.
module scsd_clk_switch (
	input wire clock,
	input wire rst_n,
	input wire sel,
	input wire a_lvl,
	input wire a_edge,
	input wire b_lvl,
	input wire b_edge,
	output reg out_q,
	output reg edge_q
);
	reg cur_q;
	reg hold_q;
	reg hold_d;
	reg cur_d;
	reg out_d;
	wire cur_lvl;
	wire new_fall;

	assign cur_lvl = cur_q ? b_lvl : a_lvl;
	assign new_fall = cur_q ? (a_edge && !a_lvl) : (b_edge && !b_lvl);

	always @* begin
		hold_d = hold_q;
		cur_d = cur_q;
		// Park low only while the old source is low
		if (!hold_q && (sel != cur_q) && !cur_lvl) begin
			hold_d = 1'b1;
		end
		// Hand over on a falling edge of the new source: full low phase
		if (hold_q && new_fall) begin
			hold_d = 1'b0;
			cur_d = ~cur_q;
		end
		if (hold_d) begin
			out_d = 1'b0;
		end else if (cur_d) begin
			out_d = b_lvl;
		end else begin
			out_d = a_lvl;
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cur_q <= 1'b0;
			hold_q <= 1'b0;
			out_q <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			cur_q <= cur_d;
			hold_q <= hold_d;
			out_q <= out_d;
			edge_q <= (out_d != out_q);
		end
	end
endmodule // scsd_clk_switch

`default_nettype wire

// ===== scsd_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module scsd_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [6:0] trim_factory,
	input wire logic ext_osc,
	input wire logic int_osc_out,
	input wire logic sysclk_out
);
	// --------------------------------
	// Shadow of the stored fields
	// --------------------------------
	reg [6:0] sd_q;
	reg [6:0] tr_q;
	reg [7:0] oc_q;
	reg ld_q;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sd_q <= 7'h00;
			tr_q <= 7'h00;
			oc_q <= 8'hc0;
			ld_q <= 1'b1;
		end else begin
			ld_q <= 1'b0;
			if (ld_q)
				tr_q <= trim_factory;
			if (reg_wr && reg_addr == 8'hbd)
				sd_q <= {reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
			if (reg_wr && reg_addr == 8'hbf)
				tr_q <= reg_wdata[6:0];
			if (reg_wr && reg_addr == 8'ha9)
				oc_q <= {reg_wdata[7], reg_wdata[7], 2'h0, reg_wdata[3], 1'b0, reg_wdata[1:0]};
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) != 8'hbd
		&& $past(reg_addr) != 8'hbf && $past(reg_addr) != 8'ha9 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	srcdiv_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hbd
		|-> reg_rdata[6:0] == $past(sd_q)) else $error("source divider readback wrong");
	bit3_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hbd
		|-> reg_rdata[3] == 1'b0) else $error("reserved bit not zero");
	trim_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hbf
		|-> reg_rdata == {1'b0, $past(tr_q)}) else $error("trim readback wrong");
	oscctl_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha9
		|-> reg_rdata == $past(oc_q)) else $error("oscillator control readback wrong");
	sys_high_a: assert property ($rose(sysclk_out) |-> sysclk_out [*3])
		else $error("system clock high phase too short");
	sys_low_a: assert property ($fell(sysclk_out) |-> !sysclk_out [*3])
		else $error("system clock low phase too short");
	osc_low_a: assert property ($fell(int_osc_out) |-> !int_osc_out [*4])
		else $error("oscillator low phase too short");
endmodule // scsd_asserts
bind scsd_clock_ctl scsd_asserts u_chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .trim_factory, .ext_osc, .int_osc_out, .sysclk_out);
`default_nettype wire

// ===== test_system_clock_select_and_divide.sv
`timescale 1ns/100ps
`default_nettype none
module test_system_clock_select_and_divide;
	logic clock, rst_n, reg_wr, reg_rd, ext_osc, a;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, m_sd, m_tr, m_oc;
	logic [6:0] trim_factory;
	logic int_osc_out, sysclk_out;
	logic [31:0] seed;
	int errors, total_checks, n, t, k, mn, mx, ec;
	int q[$];
	logic [7:0] amap [4] = '{8'hbd, 8'hbf, 8'ha9, 8'h3c};
	scsd_clock_ctl #(.HALF_BASE(4), .DITHER_UNIT(1)) u_dut (.clock, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trim_factory, .ext_osc, .int_osc_out,
		.sysclk_out);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// External oscillator, half period of five clocks
	always @(posedge clock) begin
		ec <= (ec == 4) ? 0 : ec + 1;
		if (ec == 4)
			ext_osc <= ~ext_osc;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// --------------------------------
	// Bus tasks and compares
	// --------------------------------
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		if (ad == 8'hbd) m_sd = {1'b0, d[6:4], 1'b0, d[2:0]};
		if (ad == 8'hbf) m_tr = {1'b0, d[6:0]};
		if (ad == 8'ha9) m_oc = {d[7], d[7], 2'h0, d[3], 1'b0, d[1:0]};
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
		@(posedge clock);
	endtask
	task automatic chk_reg(input logic [7:0] ad, input logic [7:0] mk, input logic [7:0] e);
		logic [7:0] d;
		rd(ad, d);
		total_checks++;
		if ((d & mk) !== (e & mk)) begin
			errors++;
			$display("BAD %0t reg %h got %h want %h", $time, ad, d, e);
		end
	endtask
	task automatic chk_num(input int got, input int e);
		total_checks++;
		if (got != e) begin
			errors++;
			$display("BAD %0t count %0d want %0d", $time, got, e);
		end
	endtask
	task automatic chk_all(input logic [7:0] mk);
		chk_reg(8'hbd, mk, m_sd);
		chk_reg(8'hbf, 8'hff, m_tr);
		chk_reg(8'ha9, 8'hff, m_oc);
		chk_reg(8'h3c, 8'hff, 8'h00);
	endtask
	// Period between the second and third rise; the first may straddle a change
	task automatic per(input bit sys, output int p);
		int r, nr;
		logic b;
		nr = 0;
		p = -1;
		a = sys ? sysclk_out : int_osc_out;
		for (k = 0; k < 9000 && p < 0; k++) begin
			@(posedge clock);
			b = sys ? sysclk_out : int_osc_out;
			if (b && !a) nr++;
			if (b && !a && nr == 2) r = k;
			if (b && !a && nr == 3) p = k - r;
			a = b;
		end
	endtask
	task automatic do_reset;
		seed = lfsr(seed);
		trim_factory <= seed[6:0];
		rst_n <= 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		m_sd = 8'h80;
		m_tr = {1'b0, seed[6:0]};
		m_oc = 8'hc0;
		repeat (2) @(posedge clock);
	endtask
	task automatic give_verdict;
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#(80000 * 100);
		errors++;
		give_verdict;
	end
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, ext_osc, reg_addr, reg_wdata, trim_factory} = '0;
		{errors, total_checks, ec} = '0;
		seed = 32'h084b6117;
		@(posedge clock);
		do_reset;
		chk_all(8'hff);
		for (n = 0; n < 40; n++) begin
			seed = lfsr(seed);
			wr(amap[seed[9:8]], (seed[7:0] & 8'hf7) | (seed[9:8] == 2 ? 8'h80 : 8'h00));
			chk_all(8'h7f);
		end
		wr(8'hbf, 8'h00);
		wr(8'hbd, 8'h00);
		for (n = 0; n < 4; n++) begin
			wr(8'ha9, 8'hc0 | n[7:0]);
			per(0, t);
			chk_num(t, 14 << (3 - n));
		end
		wr(8'hbf, 8'h7f);
		per(0, t);
		chk_num(t, 268);
		wr(8'hbf, 8'h00);
		for (n = 7; n >= 0; n--) begin
			per(1, t);
			wr(8'hbd, n[7:0] << 4);
			if (n < 7) chk_reg(8'hbd, 8'h80, 8'h00);
			for (k = 0; k < 1000 && m_sd[7] !== 1'b1; k++) rd(8'hbd, m_sd);
			chk_num(m_sd[7] === 1'b1, 1);
			per(1, t);
			chk_num(t, 14 << n);
		end
		wr(8'ha9, 8'hcb);
		q.delete();
		for (k = 0; q.size() < 390 && k < 9000; k++) begin
			@(posedge clock);
			if (int_osc_out && !a) q.push_back(k);
			a = int_osc_out;
		end
		chk_num(q[388] - q[4], 5376);
		{mn, mx} = {32'd99, 32'd0};
		for (n = 4; n < 388; n++) begin
			mn = (q[n + 1] - q[n] < mn) ? q[n + 1] - q[n] : mn;
			mx = (q[n + 1] - q[n] > mx) ? q[n + 1] - q[n] : mx;
		end
		chk_num(mx - mn, 12);
		wr(8'ha9, 8'hc3);
		per(0, t);
		chk_num(t, 14);
		wr(8'hbd, 8'h01);
		per(1, t);
		chk_num(t, 10);
		wr(8'ha9, 8'h43);
		per(0, t);
		chk_num(t, -1);
		wr(8'ha9, 8'hc3);
		wr(8'hbd, 8'h02);
		per(1, t);
		chk_num(t, 14);
		do_reset;
		chk_all(8'hff);
		give_verdict;
	end
endmodule // test_system_clock_select_and_divide
`default_nettype wire
